// ---- rtl/apc_pkg.sv ----
// Constants and types for the acquisition progress counters and
// interrupt status bank.
// Assumes one system clock; event strobes come from same-clock logic.
//
// Summary of operation
// (R1) Volume counter, 24 bits, counts each complete volume acquired.
// (R2) Frame counter, 24 bits, counts each frame acquired.
// (R3) Line counter, 24 bits, counts each line acquired.
// (R4) Word counter, 24 bits, counts acquired sixteen-byte data words.
// (R5) Writing zero to any counter clears it at once, whatever is acquiring.
// (R6) Clear mode decides what a counter does at its maximum value.
// (R7) Volume/frame/line clear select 29..28: acq, volume, frame, line start.
// (R8) Volume/frame/line update select 31..30: live, volume, frame, line end.
// (R9) Word clear select: acquisition, frame, line, word window start.
// (R10) Word update select: live, frame, line, word window end.
// (R11) Status bit 0 sets when the frame window closes.
// (R12) Status bit 1 sets when the line window closes.
// (R13) Status bit 2 sets when the volume window closes; bit 3 reserved.
// (R14) Bits 4, 5, 6 flag second encoder, first encoder and trigger events.
// (R15) Bits 7, 8, 9 flag frame, line and volume window start.
// (R16) Bits 26, 27, 28 flag buffer fault, sync loss, dropped host packet.
// (R17) Bit 29 mirrors bit 0, set and cleared together with it.
// (R18) Board enable gates the interrupt output; summary bit shows any active.
// (R19) Each status bit has a mask bit at the same position.
// (R20) Flags stay set until software clears; reserved bits read zero.
// (R21) Non-live update shows a snapshot at window end; count keeps running.
package apc_pkg;

  // Register byte offsets
  localparam logic [7:0] APC_OFF_VOLUME = 8'h00;
  localparam logic [7:0] APC_OFF_FRAME  = 8'h04;
  localparam logic [7:0] APC_OFF_LINE   = 8'h08;
  localparam logic [7:0] APC_OFF_WORD   = 8'h0c;
  localparam logic [7:0] APC_OFF_STATUS = 8'h10;
  localparam logic [7:0] APC_OFF_MASK   = 8'h14;
  localparam logic [7:0] APC_OFF_BOARD  = 8'h18;

  // Counter register fields
  localparam int APC_CNT_W      = 24;
  localparam int APC_CLR_LSB    = 28;
  localparam int APC_UPD_LSB    = 30;
  localparam logic [1:0] APC_CLR_ACQ  = 2'h0;
  localparam logic [1:0] APC_UPD_LIVE = 2'h0;

  // Status bit positions
  localparam int APC_ST_FRAME_END   = 0;
  localparam int APC_ST_LINE_END    = 1;
  localparam int APC_ST_VOLUME_END  = 2;
  localparam int APC_ST_ENC_SECOND  = 4;
  localparam int APC_ST_ENC_FIRST   = 5;
  localparam int APC_ST_TRIGGER     = 6;
  localparam int APC_ST_FRAME_START = 7;
  localparam int APC_ST_LINE_START  = 8;
  localparam int APC_ST_VOL_START   = 9;
  localparam int APC_ST_BUF_FAULT   = 26;
  localparam int APC_ST_SYNC_LOST   = 27;
  localparam int APC_ST_PKT_DROP    = 28;
  localparam int APC_ST_LEGACY      = 29;
  localparam logic [31:0] APC_ST_IMPL = 32'h3c00_03f7;

  // Board control bits
  localparam int APC_BRD_ANY    = 7;
  localparam int APC_BRD_ENABLE = 8;

  // Reset values
  localparam logic [31:0] APC_RST_WORD = 32'h0000_0000;

  // AHB encodings
  localparam logic [2:0] APC_HSIZE_WORD = 3'h2;
  localparam logic       APC_HRESP_OKAY = 1'h0;

  // One-cycle strobes from the window sequencer
  typedef struct packed {
    logic acq_start;
    logic volume_start;
    logic volume_end;
    logic frame_start;
    logic frame_end;
    logic line_start;
    logic line_end;
    logic word_start;
    logic word_end;
    logic word_done;
    logic encoder_second;
    logic encoder_first;
    logic trigger;
    logic buffer_fault;
    logic sync_lost;
    logic packet_dropped;
  } apc_events_type;

endpackage : apc_pkg

// ---- rtl/apc_counters.sv ----
// Acquisition progress counters and interrupt status, AHB-Lite slave.
// Assumes event strobes are one-cycle pulses on hclk; single word
// transfers only; ce low freezes all state and must not fall mid-transfer.
`timescale 1ns/10ps

module apc_counters (
  // Clock, reset, enable
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    ce,
  // AHB-Lite slave
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic      [31:0]             hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  // Window sequencer events
  input  wire apc_pkg::apc_events_type events,
  // Board interrupt
  output logic                         irq
);

  ////////////////////////////////////////////////////////////////////////
  // Bus state

  logic        wr_pend_reg;
  logic        rd_pend_reg;
  logic [7:0]  addr_reg;
  logic        addr_ok_reg;
  logic [31:0] hrdata_reg;
  logic        hreadyout_reg;
  logic        hresp_reg;
  logic        irq_reg;
  logic        take;
  logic        word_sized;
  logic        wr_do;
  logic [31:0] rd_mux;

  assign take = hsel & hready & htrans[1] & hreadyout_reg;
  assign word_sized = (hsize == apc_pkg::APC_HSIZE_WORD);
  assign wr_do = wr_pend_reg & addr_ok_reg;

  // Address phase capture; reads get one wait state so a write just
  // before is already visible in the data returned
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
      addr_ok_reg <= 1'b0;
    end else if (ce) begin
      wr_pend_reg <= take & hwrite & word_sized;
      rd_pend_reg <= take & ~hwrite;
      if (take) begin
        addr_reg    <= haddr[7:0];
        addr_ok_reg <= (haddr[31:8] == 24'h000000);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_reg <= 1'b1;
      hresp_reg     <= apc_pkg::APC_HRESP_OKAY;
      hrdata_reg    <= apc_pkg::APC_RST_WORD;
    end else if (ce) begin
      hresp_reg <= apc_pkg::APC_HRESP_OKAY;
      if (take && !hwrite) begin
        hreadyout_reg <= 1'b0;
      end else if (rd_pend_reg) begin
        hreadyout_reg <= 1'b1;
        hrdata_reg    <= addr_ok_reg ? rd_mux : apc_pkg::APC_RST_WORD;
      end
    end
  end

  assign hrdata    = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp     = hresp_reg;

  ////////////////////////////////////////////////////////////////////////
  // Counters: 0 volume, 1 frame, 2 line, 3 word

  logic [23:0] count_reg [4];
  logic [23:0] shown_reg [4];
  logic [1:0]  clr_sel_reg [4];
  logic [1:0]  upd_sel_reg [4];
  logic [3:0]  inc_ev;
  logic [3:0]  clr_src [4];
  logic [3:0]  upd_src [4];
  logic [3:0]  wr_cnt;

  // Counting strobes per counter
  assign inc_ev = {events.word_done,                   // [R4]
                   events.line_end,                    // [R3]
                   events.frame_end,                   // [R2]
                   events.volume_end};                 // [R1]

  // Clear sources indexed by clear select code
  assign clr_src[0] = {events.line_start, events.frame_start,
                       events.volume_start, events.acq_start}; // [R7]
  assign clr_src[1] = clr_src[0];                              // [R7]
  assign clr_src[2] = clr_src[0];                              // [R7]
  assign clr_src[3] = {events.word_start, events.line_start,
                       events.frame_start, events.acq_start};  // [R9]

  // Snapshot sources indexed by update select code; code 0 is live
  assign upd_src[0] = {events.line_end, events.frame_end,
                       events.volume_end, 1'b0};               // [R8]
  assign upd_src[1] = upd_src[0];                              // [R8]
  assign upd_src[2] = upd_src[0];                              // [R8]
  assign upd_src[3] = {events.word_end, events.line_end,
                       events.frame_end, 1'b0};                // [R10]

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_cnt
      logic [23:0] count_next;
      logic        clr_now;
      logic        upd_now;
      logic        at_max;

      assign wr_cnt[gi] = wr_do && (addr_reg == 8'(gi * 4));
      assign clr_now = clr_src[gi][clr_sel_reg[gi]];
      assign upd_now = upd_src[gi][upd_sel_reg[gi]];
      assign at_max  = (count_reg[gi] == 24'hff_ffff);

      // A clear and a count in one cycle start the new interval at one
      always_comb begin
        count_next = count_reg[gi];
        if (clr_now) begin
          count_next = 24'h00_0000;                            // [R7] [R9]
        end
        if (inc_ev[gi]) begin
          if (clr_now) begin
            count_next = 24'h00_0001;
          end else if (at_max) begin
            // Cleared only at acquisition start: hold, else wrap
            if (clr_sel_reg[gi] == apc_pkg::APC_CLR_ACQ) begin
              count_next = count_reg[gi];                      // [R6]
            end else begin
              count_next = 24'h00_0000;                        // [R6]
            end
          end else begin
            count_next = count_reg[gi] + 24'h00_0001;
          end
        end
      end

      // Running count; a software zero wins over any event
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          count_reg[gi] <= 24'h00_0000;
        end else if (ce) begin
          if (wr_cnt[gi] && hwdata[23:0] == 24'h00_0000) begin
            count_reg[gi] <= 24'h00_0000;                      // [R5]
          end else begin
            count_reg[gi] <= count_next;
          end
        end
      end

      // Readable value: live, or snapshot at the chosen window end
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          shown_reg[gi] <= 24'h00_0000;
        end else if (ce) begin
          if (wr_cnt[gi] && hwdata[23:0] == 24'h00_0000) begin
            shown_reg[gi] <= 24'h00_0000;                      // [R5]
          end else if (upd_sel_reg[gi] == apc_pkg::APC_UPD_LIVE) begin
            shown_reg[gi] <= count_next;                       // [R8] [R10]
          end else if (upd_now) begin
            shown_reg[gi] <= count_next;                       // [R21]
          end
        end
      end

      // Mode fields
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          clr_sel_reg[gi] <= 2'h0;
          upd_sel_reg[gi] <= 2'h0;
        end else if (ce && wr_cnt[gi]) begin
          clr_sel_reg[gi] <= hwdata[apc_pkg::APC_CLR_LSB +: 2]; // [R7] [R9]
          upd_sel_reg[gi] <= hwdata[apc_pkg::APC_UPD_LSB +: 2]; // [R8] [R10]
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status, mask and board control

  logic [31:0] status_reg;
  logic [31:0] mask_reg;
  logic        enable_reg;
  logic        any_reg;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic        wr_status;

  assign wr_status = wr_do && (addr_reg == apc_pkg::APC_OFF_STATUS);

  always_comb begin
    set_vec = 32'h0000_0000;
    set_vec[apc_pkg::APC_ST_FRAME_END]   = events.frame_end;      // [R11]
    set_vec[apc_pkg::APC_ST_LINE_END]    = events.line_end;       // [R12]
    set_vec[apc_pkg::APC_ST_VOLUME_END]  = events.volume_end;     // [R13]
    set_vec[apc_pkg::APC_ST_ENC_SECOND]  = events.encoder_second; // [R14]
    set_vec[apc_pkg::APC_ST_ENC_FIRST]   = events.encoder_first;  // [R14]
    set_vec[apc_pkg::APC_ST_TRIGGER]     = events.trigger;        // [R14]
    set_vec[apc_pkg::APC_ST_FRAME_START] = events.frame_start;    // [R15]
    set_vec[apc_pkg::APC_ST_LINE_START]  = events.line_start;     // [R15]
    set_vec[apc_pkg::APC_ST_VOL_START]   = events.volume_start;   // [R15]
    set_vec[apc_pkg::APC_ST_BUF_FAULT]   = events.buffer_fault;   // [R16]
    set_vec[apc_pkg::APC_ST_SYNC_LOST]   = events.sync_lost;      // [R16]
    set_vec[apc_pkg::APC_ST_PKT_DROP]    = events.packet_dropped; // [R16]
    set_vec[apc_pkg::APC_ST_LEGACY]      = events.frame_end;      // [R17]
  end

  // Write one to clear; clearing either of bits 0/29 clears both
  always_comb begin
    clr_vec = wr_status ? hwdata : 32'h0000_0000;
    if (clr_vec[apc_pkg::APC_ST_FRAME_END] ||
        clr_vec[apc_pkg::APC_ST_LEGACY]) begin
      clr_vec[apc_pkg::APC_ST_FRAME_END] = 1'b1;                  // [R17]
      clr_vec[apc_pkg::APC_ST_LEGACY]    = 1'b1;                  // [R17]
    end
  end

  // Sticky; a new event beats a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg <= apc_pkg::APC_RST_WORD;
    end else if (ce) begin
      status_reg <= ((status_reg & ~clr_vec) | set_vec)
                    & apc_pkg::APC_ST_IMPL;                       // [R20]
    end
  end

  // Mask bit set lets the matching status bit reach the summary
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_reg <= apc_pkg::APC_RST_WORD;
    end else if (ce && wr_do && addr_reg == apc_pkg::APC_OFF_MASK) begin
      mask_reg <= hwdata & apc_pkg::APC_ST_IMPL;                  // [R19]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_reg <= 1'b0;
    end else if (ce && wr_do && addr_reg == apc_pkg::APC_OFF_BOARD) begin
      enable_reg <= hwdata[apc_pkg::APC_BRD_ENABLE];
    end
  end

  // Summary and output both registered so irq comes from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      any_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else if (ce) begin
      any_reg <= |(status_reg & mask_reg);                        // [R18]
      irq_reg <= enable_reg & (|(status_reg & mask_reg));         // [R18]
    end
  end

  assign irq = irq_reg;

  ////////////////////////////////////////////////////////////////////////
  // Read mux

  function automatic logic [31:0] cnt_word(input logic [1:0]  upd,
                                           input logic [1:0]  clr,
                                           input logic [23:0] val);
    cnt_word = {upd, clr, 4'h0, val};                             // [R20]
  endfunction : cnt_word

  always_comb begin
    case (addr_reg)
      apc_pkg::APC_OFF_VOLUME:
        rd_mux = cnt_word(upd_sel_reg[0], clr_sel_reg[0], shown_reg[0]);
      apc_pkg::APC_OFF_FRAME:
        rd_mux = cnt_word(upd_sel_reg[1], clr_sel_reg[1], shown_reg[1]);
      apc_pkg::APC_OFF_LINE:
        rd_mux = cnt_word(upd_sel_reg[2], clr_sel_reg[2], shown_reg[2]);
      apc_pkg::APC_OFF_WORD:
        rd_mux = cnt_word(upd_sel_reg[3], clr_sel_reg[3], shown_reg[3]);
      apc_pkg::APC_OFF_STATUS:
        rd_mux = status_reg;
      apc_pkg::APC_OFF_MASK:
        rd_mux = mask_reg;
      apc_pkg::APC_OFF_BOARD:
        rd_mux = {23'h000000, enable_reg, any_reg, 7'h00};
      default:
        rd_mux = apc_pkg::APC_RST_WORD;
    endcase
  end

endmodule : apc_counters

// ---- tb/apc_seq_model.sv ----
// Stand-in for the window sequencer: replays a requested strobe word
// as one-cycle pulses one clock later.
// Assumes the bench changes req just after a rising edge of hclk.
`timescale 1ns/10ps

module apc_seq_model (
  // Clock and reset
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  // Request from the bench
  input  wire logic [15:0]             req,
  // Strobes to the counter bank
  output apc_pkg::apc_events_type      events
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      events <= '0;
    end else begin
      events <= apc_pkg::apc_events_type'(req);
    end
  end
endmodule : apc_seq_model

// ---- tb/apc_counters_sva.sv ----
// Checker for the bus handshake and interrupt output of the bank.
// Assumes hready is tied to hreadyout and ce stays high around writes.
`timescale 1ns/10ps

module apc_counters_chk (
  // Clock and reset
  input wire logic                    hclk,
  input wire logic                    hresetn,
  input wire logic                    ce,
  // Bus
  input wire logic                    hsel,
  input wire logic [1:0]              htrans,
  input wire logic                    hwrite,
  input wire logic                    hready,
  input wire logic [31:0]             hrdata,
  input wire logic                    hreadyout,
  input wire logic                    hresp,
  // Events and interrupt
  input wire apc_pkg::apc_events_type events,
  input wire logic                    irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic       take;
  logic       wr_dp;
  logic [2:0] age;
  assign take = hsel & hready & htrans[1] & ce;
  // Cycles since the last event or register write, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_dp <= 1'b0;
      age   <= 3'h7;
    end else begin
      wr_dp <= take & hwrite;
      if ((events != '0) || wr_dp) age <= 3'h0;
      else if (age != 3'h7) age <= age + 3'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////
  sequence read_wait_s;
    !hreadyout ##1 hreadyout;
  endsequence
  hresp_okay_a: assert property (hresp == apc_pkg::APC_HRESP_OKAY)
    else $error("hresp not OKAY");
  write_nowait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write stretched");
  read_wait_a: assert property (take && !hwrite |=> read_wait_s)
    else $error("read wait not one cycle");
  ready_idle_a: assert property (
    !hreadyout |-> $past(take && !hwrite))
    else $error("hreadyout low without read");
  hrdata_hold_a: assert property (
    $changed(hrdata) |-> $past(!hreadyout))
    else $error("hrdata changed outside read");
  state_freeze_a: assert property (
    !ce |=> $stable(irq) && $stable(hrdata))
    else $error("state moved with ce low");
  irq_rise_a: assert property ($rose(irq) |-> age <= 3'h3)
    else $error("irq rose without cause");
  irq_fall_a: assert property (
    $fell(irq) |-> $past(wr_dp, 2) || $past(wr_dp, 3))
    else $error("irq fell without write");
endmodule : apc_counters_chk

bind apc_counters apc_counters_chk chk (.hclk(hclk), .hresetn(hresetn),
  .ce(ce), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .events(events),
  .irq(irq));

// ---- tb/acquisition_progress_counters_irq_bench.sv ----
// Self-checking bench: random events and register traffic against a model.
// Assumes one AHB slave, so hready is fed back from hreadyout.
`timescale 1ns/10ps

module acquisition_progress_counters_irq_bench;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        ce = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = '0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = apc_pkg::APC_HSIZE_WORD;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic [15:0] req = '0;
  apc_pkg::apc_events_type events;
  int          mismatches = 0;
  int          compares = 0;
  int          live[4] = '{0, 0, 0, 0};
  int          shown[4] = '{0, 0, 0, 0};
  logic [1:0]  clr[4] = '{2'h0, 2'h0, 2'h0, 2'h0};
  logic [1:0]  upd[4] = '{2'h0, 2'h0, 2'h0, 2'h0};
  logic [31:0] st = '0;
  logic [31:0] msk = '0;
  logic [31:0] rd;
  logic [31:0] v;
  logic        en = 1'b0;
  // Strobe bit positions per counter, volume/frame/line/word
  int cnt_ev[4] = '{13, 11, 9, 6};
  int clr_ev[4][4] = '{'{15, 14, 12, 10}, '{15, 14, 12, 10},
                       '{15, 14, 12, 10}, '{15, 12, 10, 8}};
  int upd_ev[4][4] = '{'{0, 13, 11, 9}, '{0, 13, 11, 9},
                       '{0, 13, 11, 9}, '{0, 11, 9, 7}};
  int st_of[16] = '{28, 27, 26, 6, 5, 4, -1, -1, -1, 1, 8, 0, 7, 2, 9, -1};

  always #5 hclk = ~hclk;

  apc_counters uut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .events(events), .irq(irq));
  apc_seq_model seq (.hclk(hclk), .hresetn(hresetn), .req(req),
    .events(events));
  ////////////////////////////////////////////////////////////////////
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  // Waits as long as the slave stalls; the watchdog bounds the run
  task automatic wait_ready();
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
  endtask : wait_ready

  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask : bus

  task automatic wr(logic [7:0] a, logic [31:0] d);
    int c;
    c = a[3:2];
    bus(1'b1, a, d);
    if (a < apc_pkg::APC_OFF_STATUS) begin
      clr[c] = d[29:28];
      upd[c] = d[31:30];
      if (d[23:0] == 24'h0) begin
        live[c] = 0;
        shown[c] = 0;
      end
    end
    if (a == apc_pkg::APC_OFF_STATUS)
      st &= ~(d | ((d[0] | d[29]) ? 32'h2000_0001 : 32'h0));
    if (a == apc_pkg::APC_OFF_MASK) msk = d & apc_pkg::APC_ST_IMPL;
    if (a == apc_pkg::APC_OFF_BOARD) en = d[8];
  endtask : wr

  function automatic logic [31:0] expect_of(logic [7:0] a);
    int c;
    c = a[3:2];
    if (a < 8'h10) return {upd[c], clr[c], 4'h0, 24'(shown[c])};
    if (a == apc_pkg::APC_OFF_STATUS) return st;
    if (a == apc_pkg::APC_OFF_MASK) return msk;
    if (a == apc_pkg::APC_OFF_BOARD)
      return {23'h0, en, ((st & msk) != 0), 7'h0};
    return 32'h0;
  endfunction : expect_of

  task automatic rd_chk(logic [7:0] a);
    bus(1'b0, a, 32'h0);
    check($sformatf("reg_%h", a), rd, expect_of(a));
  endtask : rd_chk

  // One strobe word; the model follows the counter and status rules
  task automatic fire(logic [15:0] e);
    req <= e;
    @(posedge hclk);
    for (int c = 0; c < 4; c++) begin
      if (e[clr_ev[c][clr[c]]]) live[c] = e[cnt_ev[c]];
      else if (e[cnt_ev[c]]) live[c]++;
      if (upd[c] == 2'h0 || e[upd_ev[c][upd[c]]]) shown[c] = live[c];
    end
    for (int b = 0; b < 16; b++)
      if (e[b] && st_of[b] >= 0) st[st_of[b]] = 1'b1;
    if (e[11]) st[29] = 1'b1;
  endtask : fire
  ////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    mismatches++;
    close_out();
  end

  initial begin
    void'($urandom(72));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int a = 0; a < 32; a += 4) rd_chk(8'(a));
    wr(apc_pkg::APC_OFF_MASK, 32'hffff_ffff);
    rd_chk(apc_pkg::APC_OFF_MASK);
    for (int r = 0; r < 24; r++) begin
      for (int c = 0; c < 4; c++) begin
        v = $urandom;
        v[23:0] = (r % 3 == 0) ? 24'h0 : 24'h1;
        wr(8'(4 * c), v);
      end
      wr(apc_pkg::APC_OFF_BOARD, $urandom);
      wr(apc_pkg::APC_OFF_MASK, $urandom);
      repeat ($urandom_range(60, 1)) fire(16'($urandom & $urandom & $urandom));
      req <= 16'h0;
      repeat (3) @(posedge hclk);
      for (int a = 0; a < 28; a += 4) begin
        rd_chk(8'(a));
      end
      check("irq", {31'h0, irq}, {31'h0, en && ((st & msk) != 0)});
      wr(apc_pkg::APC_OFF_STATUS, $urandom);
    end
    // A frame-end strobe while ce is low must leave the frame count alone
    ce <= 1'b0;
    req <= 16'h0800;
    @(posedge hclk);
    req <= 16'h0;
    repeat (3) @(posedge hclk);
    ce <= 1'b1;
    @(posedge hclk);
    rd_chk(8'h04);
    // A half-word write must leave the mask as it was
    hsize <= 3'h1;
    bus(1'b1, apc_pkg::APC_OFF_MASK, ~msk);
    hsize <= apc_pkg::APC_HSIZE_WORD;
    rd_chk(apc_pkg::APC_OFF_MASK);
    // Reset in mid-run brings every register back to zero
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check("irq_reset", {31'h0, irq}, 32'h0);
    for (int a = 0; a < 28; a += 4) begin
      bus(1'b0, 8'(a), 32'h0);
      check("reg_reset", rd, apc_pkg::APC_RST_WORD);
    end
    close_out();
  end
endmodule : acquisition_progress_counters_irq_bench
